// ==== rtl/trib_port_pkg.sv ====
// constants shared by the tributary port controller and its per-port monitor
// assumes a single 40 MHz clock and a plain address/strobe register port
package trib_port_pkg;

    localparam int          NUM_PORTS      = 8;
    localparam int          CNT_W          = 16;

    // line interface mode codes
    localparam logic [1:0]  MODE_E1_75     = 2'h0;
    localparam logic [1:0]  MODE_E1_120    = 2'h1;
    localparam logic [1:0]  MODE_T1_100    = 2'h2;

    // loopback setting per port, two bits each
    typedef enum logic [1:0] {
        LB_OFF,
        LB_LOCAL,
        LB_REMOTE,
        LB_FAR_REQ
    } loop_sel_t;

    // register byte offsets
    localparam logic [7:0]  MODE_OFS       = 8'h00;
    localparam logic [7:0]  SERVICE_OFS    = 8'h04;
    localparam logic [7:0]  LINECODE_OFS   = 8'h08;
    localparam logic [7:0]  AUTO_AIS_OFS   = 8'h0C;
    localparam logic [7:0]  LOOP_OFS       = 8'h10;
    localparam logic [7:0]  CLEAR_OFS      = 8'h14;
    localparam logic [7:0]  LIVE_OFS       = 8'h18;
    localparam logic [7:0]  IRQ_STAT_OFS   = 8'h1C;
    localparam logic [7:0]  IRQ_MASK_OFS   = 8'h20;
    localparam logic [2:0]  PERF_PAGE      = 3'h2;
    localparam logic [2:0]  UAS_PAGE       = 3'h3;

    // field positions inside the live status word
    localparam int          LIVE_LOS_POS   = 0;
    localparam int          LIVE_AIS_POS   = 8;
    localparam int          LIVE_LCV_POS   = 16;
    localparam int          LIVE_TXF_POS   = 24;

    // reset values
    localparam logic [1:0]  MODE_RST       = 2'h0;
    localparam logic [7:0]  SERVICE_RST    = 8'hFF;
    localparam logic [7:0]  LINECODE_RST   = 8'hFF;
    localparam logic [7:0]  AUTO_AIS_RST   = 8'h00;
    localparam logic [15:0] LOOP_RST       = 16'h0000;
    localparam logic [15:0] IRQ_MASK_RST   = 16'h0000;

    // one-second tick for the unavailable seconds count
    localparam int          CLK_HZ         = 40_000_000;
    localparam int          SEC_TIME_MS    = 1000;
    localparam int          SEC_CYCLES     = CLK_HZ / 1000 * SEC_TIME_MS;

endpackage : trib_port_pkg

// ==== rtl/trib_port_mon.sv ====
// per-port error and unavailable-seconds monitor
// assumes error and alarm inputs synchronous to core_clk_i, sec_tick_i one cycle
`timescale 1ns/1ps
module trib_port_mon (
    input  wire logic                          core_clk_i,
    input  wire logic                          srst_i,
    input  wire logic                          service_i,
    input  wire logic                          los_i,
    input  wire logic                          ais_i,
    input  wire logic                          code_err_i,
    input  wire logic                          sec_tick_i,
    input  wire logic                          clr_perf_i,
    output logic [trib_port_pkg::CNT_W-1:0]    perf_o,
    output logic [trib_port_pkg::CNT_W-1:0]    uas_o,
    output logic                               lcv_o
);
    logic [trib_port_pkg::CNT_W-1:0] perf_reg, perf_next;
    logic [trib_port_pkg::CNT_W-1:0] uas_reg, uas_next;
    logic                            bad_reg, bad_next;
    logic                            lcv_reg, lcv_next;
    logic                            bad_now;

    always_comb begin
        bad_now   = service_i & (los_i | ais_i);
        perf_next = perf_reg;
        if (clr_perf_i) begin
            perf_next = '0;
        end else if (service_i && code_err_i && perf_reg != '1) begin
            perf_next = perf_reg + 1'b1;
        end
        uas_next = uas_reg;
        bad_next = bad_reg | bad_now;
        if (sec_tick_i) begin
            bad_next = bad_now;
            if ((bad_reg | bad_now) && uas_reg != '1) begin
                uas_next = uas_reg + 1'b1;
            end
        end
        // flag holds through the second in which an error was seen
        lcv_next = lcv_reg;
        if (sec_tick_i) begin
            lcv_next = 1'b0;
        end
        if (service_i && code_err_i) begin
            lcv_next = 1'b1;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            perf_reg <= '0;
            uas_reg  <= '0;
            bad_reg  <= 1'b0;
            lcv_reg  <= 1'b0;
        end else begin
            perf_reg <= perf_next;
            uas_reg  <= uas_next;
            bad_reg  <= bad_next;
            lcv_reg  <= lcv_next;
        end
    end

    assign perf_o = perf_reg;
    assign uas_o  = uas_reg;
    assign lcv_o  = lcv_reg;

    default clocking mon_cb @(posedge core_clk_i); endclocking
    default disable iff (srst_i);

    perf_clear_a: assert property (clr_perf_i |=> perf_reg == '0)
        else $error("performance count not zero after clear");
    perf_count_a: assert property (service_i && code_err_i && !clr_perf_i
                                   && perf_reg != '1 |=> perf_reg == $past(perf_reg) + 1'b1)
        else $error("performance count missed an error");
    lcv_raise_a: assert property (service_i && code_err_i |=> lcv_reg)
        else $error("violation flag not raised");
    uas_idle_a: assert property (!sec_tick_i |=> $stable(uas_reg))
        else $error("unavailable seconds moved without a tick");
endmodule : trib_port_mon

// ==== rtl/trib_port_ctrl.sv ====
// E1/T1 tributary port control: mode, line code, service, auto AIS,
// loopback, alarm status, performance and unavailable-seconds counts
// assumes line interface status inputs synchronous to core_clk_i and a
// register master that never issues read and write strobes together
//
// Added by the designer: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module trib_port_ctrl #(
    parameter int SEC_CYCLES = trib_port_pkg::SEC_CYCLES
) (
    input  wire logic                              core_clk_i,
    input  wire logic                              srst_i,
    // register port
    input  wire logic [7:0]                        addr_i,
    input  wire logic [31:0]                       wdata_i,
    input  wire logic                              we_i,
    input  wire logic                              re_i,
    output logic      [31:0]                       rdata_o,
    // board strap
    input  wire logic                              coax_model_i,
    // line interface unit status
    input  wire logic [trib_port_pkg::NUM_PORTS-1:0] rx_los_i,
    input  wire logic [trib_port_pkg::NUM_PORTS-1:0] rx_ais_i,
    input  wire logic [trib_port_pkg::NUM_PORTS-1:0] rx_code_err_i,
    input  wire logic [trib_port_pkg::NUM_PORTS-1:0] tx_fault_i,
    // line interface unit control
    output logic      [1:0]                        line_mode_o,
    output logic [trib_port_pkg::NUM_PORTS-1:0]    subst_code_o,
    output logic [trib_port_pkg::NUM_PORTS-1:0]    tx_ais_o,
    output logic [trib_port_pkg::NUM_PORTS-1:0]    local_line_loopback_o,
    output logic [trib_port_pkg::NUM_PORTS-1:0]    remote_line_loopback_o,
    output logic [trib_port_pkg::NUM_PORTS-1:0]    far_loopback_request_o,
    output logic                                   alarm_o,
    output logic                                   irq_o
);
    localparam int N = trib_port_pkg::NUM_PORTS;
    localparam logic [25:0] SEC_LAST = 26'(SEC_CYCLES - 1);

    ////////////////////////////////////////////////////////////////////////////
    // configuration registers
    logic [1:0]    mode_reg, mode_next;
    logic [N-1:0]  service_reg, service_next;
    logic [N-1:0]  linecode_reg, linecode_next;
    logic [N-1:0]  auto_ais_reg, auto_ais_next;
    logic [2*N-1:0] loop_reg, loop_next;
    logic [15:0]   irq_mask_reg, irq_mask_next;
    logic [N-1:0]  clr_perf_reg, clr_perf_next;
    logic          coax_reg;
    logic          wr_mode;

    always_comb begin
        mode_next     = mode_reg;
        service_next  = service_reg;
        linecode_next = linecode_reg;
        auto_ais_next = auto_ais_reg;
        loop_next     = loop_reg;
        irq_mask_next = irq_mask_reg;
        clr_perf_next = '0;
        wr_mode       = we_i && addr_i == trib_port_pkg::MODE_OFS;
        if (coax_reg) begin
            mode_next = trib_port_pkg::MODE_E1_75;
        end else if (wr_mode && wdata_i[1:0] != 2'h3) begin
            mode_next = wdata_i[1:0];
        end
        if (we_i) begin
            case (addr_i)
                trib_port_pkg::SERVICE_OFS:  service_next  = wdata_i[N-1:0];
                trib_port_pkg::LINECODE_OFS: linecode_next = wdata_i[N-1:0];
                trib_port_pkg::AUTO_AIS_OFS: auto_ais_next = wdata_i[N-1:0];
                trib_port_pkg::LOOP_OFS:     loop_next     = wdata_i[2*N-1:0];
                trib_port_pkg::IRQ_MASK_OFS: irq_mask_next = wdata_i[15:0];
                trib_port_pkg::CLEAR_OFS:    clr_perf_next = wdata_i[N-1:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            mode_reg     <= trib_port_pkg::MODE_RST;
            service_reg  <= trib_port_pkg::SERVICE_RST;
            linecode_reg <= trib_port_pkg::LINECODE_RST;
            auto_ais_reg <= trib_port_pkg::AUTO_AIS_RST;
            loop_reg     <= trib_port_pkg::LOOP_RST;
            irq_mask_reg <= trib_port_pkg::IRQ_MASK_RST;
            clr_perf_reg <= '0;
            coax_reg     <= 1'b0;
        end else begin
            mode_reg     <= mode_next;
            service_reg  <= service_next;
            linecode_reg <= linecode_next;
            auto_ais_reg <= auto_ais_next;
            loop_reg     <= loop_next;
            irq_mask_reg <= irq_mask_next;
            clr_perf_reg <= clr_perf_next;
            coax_reg     <= coax_model_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // one-second tick
    logic [25:0] sec_cnt_reg, sec_cnt_next;
    logic        sec_tick;

    always_comb begin
        sec_tick     = sec_cnt_reg == SEC_LAST;
        sec_cnt_next = sec_tick ? '0 : sec_cnt_reg + 1'b1;
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            sec_cnt_reg <= '0;
        end else begin
            sec_cnt_reg <= sec_cnt_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // per-port monitors
    logic [trib_port_pkg::CNT_W-1:0] perf_cnt [N];
    logic [trib_port_pkg::CNT_W-1:0] uas_cnt  [N];
    logic [N-1:0]                    lcv_flag;

    for (genvar p = 0; p < N; p++) begin : g_port
        trib_port_mon u_mon (
            .core_clk_i (core_clk_i),
            .srst_i     (srst_i),
            .service_i  (service_reg[p]),
            .los_i      (rx_los_i[p]),
            .ais_i      (rx_ais_i[p]),
            .code_err_i (rx_code_err_i[p]),
            .sec_tick_i (sec_tick),
            .clr_perf_i (clr_perf_reg[p]),
            .perf_o     (perf_cnt[p]),
            .uas_o      (uas_cnt[p]),
            .lcv_o      (lcv_flag[p])
        );
    end

    ////////////////////////////////////////////////////////////////////////////
    // live status, line interface controls and alarm
    logic [31:0]  live_reg, live_next;
    logic [N-1:0] tx_ais_reg, tx_ais_next;
    logic [N-1:0] lloop_reg, lloop_next;
    logic [N-1:0] rloop_reg, rloop_next;
    logic [N-1:0] floop_reg, floop_next;
    logic [N-1:0] subst_reg;
    logic [1:0]   line_mode_reg;
    logic         alarm_reg, alarm_next;
    trib_port_pkg::loop_sel_t sel;

    always_comb begin
        live_next = '0;
        sel       = trib_port_pkg::LB_OFF;
        for (int i = 0; i < N; i++) begin
            live_next[trib_port_pkg::LIVE_LOS_POS + i] = rx_los_i[i];
            live_next[trib_port_pkg::LIVE_AIS_POS + i] = rx_ais_i[i];
            live_next[trib_port_pkg::LIVE_LCV_POS + i] = lcv_flag[i];
            live_next[trib_port_pkg::LIVE_TXF_POS + i] = tx_fault_i[i];
            tx_ais_next[i] = service_reg[i] & auto_ais_reg[i] & rx_los_i[i];
            // only the loop field steers the paths, so off restores them
            sel           = trib_port_pkg::loop_sel_t'(loop_reg[2*i +: 2]);
            lloop_next[i] = sel == trib_port_pkg::LB_LOCAL;
            rloop_next[i] = sel == trib_port_pkg::LB_REMOTE;
            floop_next[i] = sel == trib_port_pkg::LB_FAR_REQ;
        end
        alarm_next = |(service_reg & rx_los_i);
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            live_reg      <= '0;
            tx_ais_reg    <= '0;
            lloop_reg     <= '0;
            rloop_reg     <= '0;
            floop_reg     <= '0;
            subst_reg     <= trib_port_pkg::LINECODE_RST;
            line_mode_reg <= trib_port_pkg::MODE_RST;
            alarm_reg     <= 1'b0;
        end else begin
            live_reg      <= live_next;
            tx_ais_reg    <= tx_ais_next;
            lloop_reg     <= lloop_next;
            rloop_reg     <= rloop_next;
            floop_reg     <= floop_next;
            subst_reg     <= linecode_reg;
            line_mode_reg <= mode_reg;
            alarm_reg     <= alarm_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupts: [7:0] loss of signal rising, [15:8] violation rising
    logic [15:0] irq_stat_reg, irq_stat_next;
    logic [N-1:0] los_prev_reg, lcv_prev_reg;
    logic [15:0] irq_set;
    logic        irq_reg, irq_next;

    always_comb begin
        irq_set       = {lcv_flag & ~lcv_prev_reg, rx_los_i & ~los_prev_reg & service_reg};
        irq_stat_next = irq_stat_reg;
        if (we_i && addr_i == trib_port_pkg::IRQ_STAT_OFS) begin
            irq_stat_next = irq_stat_reg & ~wdata_i[15:0];
        end
        // a new event wins over a clear in the same cycle
        irq_stat_next = irq_stat_next | irq_set;
        irq_next      = |(irq_stat_next & irq_mask_next);
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            irq_stat_reg <= '0;
            los_prev_reg <= '0;
            lcv_prev_reg <= '0;
            irq_reg      <= 1'b0;
        end else begin
            irq_stat_reg <= irq_stat_next;
            los_prev_reg <= rx_los_i;
            lcv_prev_reg <= lcv_flag;
            irq_reg      <= irq_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register read port, data one cycle after the strobe
    logic [31:0] rdata_reg, rdata_next;

    always_comb begin
        rdata_next = '0;
        if (re_i) begin
            case (addr_i)
                trib_port_pkg::MODE_OFS:     rdata_next = {30'h0, mode_reg};
                trib_port_pkg::SERVICE_OFS:  rdata_next = {24'h0, service_reg};
                trib_port_pkg::LINECODE_OFS: rdata_next = {24'h0, linecode_reg};
                trib_port_pkg::AUTO_AIS_OFS: rdata_next = {24'h0, auto_ais_reg};
                trib_port_pkg::LOOP_OFS:     rdata_next = {16'h0, loop_reg};
                trib_port_pkg::LIVE_OFS:     rdata_next = live_reg;
                trib_port_pkg::IRQ_STAT_OFS: rdata_next = {16'h0, irq_stat_reg};
                trib_port_pkg::IRQ_MASK_OFS: rdata_next = {16'h0, irq_mask_reg};
                default: begin
                    if (addr_i[7:5] == trib_port_pkg::PERF_PAGE && addr_i[1:0] == 2'h0) begin
                        rdata_next = {16'h0, perf_cnt[addr_i[4:2]]};
                    end else if (addr_i[7:5] == trib_port_pkg::UAS_PAGE
                                 && addr_i[1:0] == 2'h0) begin
                        rdata_next = {14'h0, mode_reg, uas_cnt[addr_i[4:2]]};
                    end
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            rdata_reg <= '0;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign rdata_o                = rdata_reg;
    assign line_mode_o            = line_mode_reg;
    assign subst_code_o           = subst_reg;
    assign tx_ais_o               = tx_ais_reg;
    assign local_line_loopback_o  = lloop_reg;
    assign remote_line_loopback_o = rloop_reg;
    assign far_loopback_request_o = floop_reg;
    assign alarm_o                = alarm_reg;
    assign irq_o                  = irq_reg;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking ctl_cb @(posedge core_clk_i); endclocking
    default disable iff (srst_i);

    sequence loop_off_wr_s;
        we_i && addr_i == trib_port_pkg::LOOP_OFS && wdata_i[2*N-1:0] == '0;
    endsequence
    sequence paths_normal_s;
        ##2 (lloop_reg | rloop_reg | floop_reg) == '0;
    endsequence

    mode_select_a: assert property (!coax_reg && wr_mode && wdata_i[1:0] != 2'h3
                                    |=> ##1 line_mode_o == $past(wdata_i[1:0], 2))
        else $error("selected mode not applied");
    coax_mode_a: assert property (coax_reg |=> ##1 line_mode_o == trib_port_pkg::MODE_E1_75)
        else $error("coax model left E1 75 ohm");
    line_code_a: assert property (##1 subst_code_o == $past(linecode_reg))
        else $error("line code not driven");
    auto_ais_a: assert property (service_reg[0] && auto_ais_reg[0] && rx_los_i[0]
                                 |=> tx_ais_o[0])
        else $error("auto AIS not sent on loss of signal");
    out_service_a: assert property ((service_reg & rx_los_i) == '0 |=> !alarm_o)
        else $error("alarm from out of service port");
    los_status_a: assert property (rx_los_i[0] |=> live_reg[trib_port_pkg::LIVE_LOS_POS])
        else $error("loss of signal not reported");
    rx_ais_a: assert property (rx_ais_i != '0
        |=> live_reg[trib_port_pkg::LIVE_AIS_POS +: N] == $past(rx_ais_i))
        else $error("received AIS not flagged");
    tx_fail_a: assert property (tx_fault_i != '0
        |=> live_reg[trib_port_pkg::LIVE_TXF_POS +: N] == $past(tx_fault_i))
        else $error("driver failure not reported");
    lcv_status_a: assert property (##1 live_reg[trib_port_pkg::LIVE_LCV_POS +: N]
        == $past(lcv_flag))
        else $error("violation flag not reported");
    loop_local_a: assert property (we_i && addr_i == trib_port_pkg::LOOP_OFS
        && wdata_i[7:6] == 2'h1 |=> ##1 local_line_loopback_o[3])
        else $error("local loopback not applied");
    loop_remote_a: assert property (we_i && addr_i == trib_port_pkg::LOOP_OFS
        && wdata_i[7:6] == 2'h2 |=> ##1 remote_line_loopback_o[3])
        else $error("remote loopback not applied");
    loop_far_a: assert property (we_i && addr_i == trib_port_pkg::LOOP_OFS
        && wdata_i[7:6] == 2'h3 |=> ##1 far_loopback_request_o[3])
        else $error("far loopback request not sent");
    loop_off_a: assert property (loop_off_wr_s |-> paths_normal_s)
        else $error("loopback not removed");
    irq_set_a: assert property (irq_set[0] |=> irq_stat_reg[0])
        else $error("event lost against clear");
    irq_level_a: assert property (irq_o == |(irq_stat_reg & irq_mask_reg))
        else $error("interrupt level does not follow unmasked status");
    alarm_los_a: assert property ((service_reg & rx_los_i) != '0 |=> alarm_o)
        else $error("alarm missing for in-service loss of signal");
    ais_idle_a: assert property ((service_reg & auto_ais_reg & rx_los_i) == '0
        |=> tx_ais_o == '0)
        else $error("AIS sent without loss of signal");
    mode_reserved_a: assert property (!coax_reg && wr_mode && wdata_i[1:0] == 2'h3
        |=> $stable(mode_reg))
        else $error("reserved mode code accepted");
    read_idle_a: assert property (!re_i |=> rdata_o == '0)
        else $error("read data outside the read cycle");
endmodule : trib_port_ctrl

// ==== sim/line_equip_model.sv ====
// far-end E1/T1 line terminal as seen through the line interface unit status pins
// assumes the bench drives its command inputs by non-blocking assignment at core_clk_i
`timescale 1ns/1ps
module line_equip_model (
    input  wire logic       core_clk_i,
    input  wire logic [7:0] los_cmd_i,
    input  wire logic [7:0] lost_us_i,
    input  wire logic [7:0] err_cmd_i,
    input  wire logic [7:0] fault_cmd_i,
    output logic      [7:0] rx_los_o,
    output logic      [7:0] rx_ais_o,
    output logic      [7:0] rx_code_err_o,
    output logic      [7:0] tx_fault_o
);
    always_ff @(posedge core_clk_i) begin
        rx_los_o      <= los_cmd_i;
        rx_ais_o      <= lost_us_i & ~los_cmd_i;
        rx_code_err_o <= err_cmd_i;
        tx_fault_o    <= fault_cmd_i;
    end
endmodule : line_equip_model

// ==== sim/e1t1_tributary_port_ctrl_tb.sv ====
// self-checking bench for the tributary port controller
// assumes the line equipment model in its own file; one 40 MHz clock
`timescale 1ns/1ps
module e1t1_tributary_port_ctrl_tb;
    logic clk = 0, srst = 1, we = 0, re = 0, coax = 0, alarm, irq;
    logic [7:0]  addr = 0, los = 0, lost = 0, err = 0, flt = 0, rlos, rais, rerr, rflt;
    logic [31:0] wdata = 0, rdata, d;
    logic [1:0]  mode;
    logic [7:0]  subst, txais, local_line_loopback, remote_line_loopback, flb;
    int mismatches = 0, cmp_count = 0;
    always #12.5 clk = ~clk;
    trib_port_ctrl #(.SEC_CYCLES(20)) trib_port_ctrl_i (.core_clk_i(clk), .srst_i(srst),
        .addr_i(addr), .wdata_i(wdata), .we_i(we), .re_i(re), .rdata_o(rdata),
        .coax_model_i(coax), .rx_los_i(rlos), .rx_ais_i(rais), .rx_code_err_i(rerr),
        .tx_fault_i(rflt), .line_mode_o(mode), .subst_code_o(subst), .tx_ais_o(txais),
        .local_line_loopback_o(local_line_loopback), .remote_line_loopback_o(remote_line_loopback),
        .far_loopback_request_o(flb), .alarm_o(alarm), .irq_o(irq));
    line_equip_model line_equip_model_i (.core_clk_i(clk), .los_cmd_i(los), .lost_us_i(lost),
        .err_cmd_i(err), .fault_cmd_i(flt), .rx_los_o(rlos), .rx_ais_o(rais),
        .rx_code_err_o(rerr), .tx_fault_o(rflt));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        we <= 1; addr <= a; wdata <= v;
        @(posedge clk);
        we <= 0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk);
        re <= 1; addr <= a;
        @(posedge clk);
        re <= 0;
        #1 v = rdata;
    endtask : rd
    task automatic finish_test;
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : finish_test
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        rd(8'h04, d); chk(d, 32'h0000_00FF);
        rd(8'h08, d); chk(d, 32'h0000_00FF);
        rd(8'h40, d); chk(d, 32'h0);
        chk({24'h0, subst}, 32'h0000_00FF);
        wr(8'h08, 32'h0000_00F0); cyc(2); chk({24'h0, subst}, 32'h0000_00F0);
        $display("reset test done");
    endtask : t_reset
    task automatic t_mode;
        for (int m = 1; m < 4; m++) begin
            wr(8'h00, m); cyc(2);
            chk({30'h0, mode}, (m == 3) ? 32'h2 : m);
        end
        $display("mode test done");
    endtask : t_mode
    task automatic t_los;
        wr(8'h20, 32'h0000_0001); wr(8'h0C, 32'h0000_0001);
        los <= 8'h01; cyc(4);
        chk({29'h0, txais[0], alarm, irq}, 32'h7);
        rd(8'h18, d); chk(d & 32'hFF, 32'h1);
        wr(8'h04, 32'h0000_00FE); cyc(3); chk({31'h0, alarm}, 32'h0);
        chk({31'h0, txais[0]}, 32'h0);
        los <= 0; wr(8'h04, 32'h0000_00FF); wr(8'h1C, 32'h0000_0001); cyc(3);
        chk({30'h0, alarm, irq}, 32'h0);
        $display("los test done");
    endtask : t_los
    task automatic t_err;
        repeat (3) begin
            @(posedge clk) err <= 8'h02;
            @(posedge clk) err <= 8'h00;
        end
        cyc(4); rd(8'h44, d); chk(d, 32'h3);
        rd(8'h1C, d); chk(d & 32'h200, 32'h200);
        wr(8'h14, 32'h0000_0002); cyc(3); rd(8'h44, d); chk(d, 32'h0);
        lost <= 8'h10; flt <= 8'h20; cyc(3); rd(8'h18, d);
        chk(d & 32'hFF00_FF00, 32'h2000_1000);
        lost <= 0; flt <= 0;
        $display("error test done");
    endtask : t_err
    task automatic t_uas;
        los <= 8'h04; cyc(45); los <= 0; cyc(2);
        rd(8'h68, d); chk({30'h0, d[17:16]}, 32'h2);
        // 45 cycles of loss at a 20-cycle second span two or three ticks, plus one trailing
        chk({31'h0, d[15:0] >= 16'h2 && d[15:0] <= 16'h4}, 32'h1);
        $display("unavailable seconds test done");
    endtask : t_uas
    task automatic t_loop;
        for (int k = 0; k < 4; k++) begin
            wr(8'h10, k << 6); cyc(2);
            chk({29'h0, local_line_loopback[3], remote_line_loopback[3], flb[3]}, (k == 0) ? 0 : 1 << (3 - k));
        end
        wr(8'h10, 32'h0); cyc(2); chk({local_line_loopback, remote_line_loopback, flb, subst}, 32'h0000_00F0);
        $display("loopback test done");
    endtask : t_loop
    task automatic t_coax;
        @(posedge clk) coax <= 1;
        cyc(3); chk({30'h0, mode}, 32'h0);
        wr(8'h00, 32'h1); cyc(2); chk({30'h0, mode}, 32'h0);
        $display("coax test done");
    endtask : t_coax
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(posedge clk);
        srst <= 0;
        cyc(1);
        t_reset; t_mode; t_los; t_err; t_uas; t_loop; t_coax;
        finish_test;
    end
    initial begin
        #500000;
        mismatches++;
        finish_test;
    end
endmodule : e1t1_tributary_port_ctrl_tb
